/* File: hdl/dss_pkg.sv */
// Purpose: Shared constants and types for the servo and spindle sequencer
// Assumes: 100 MHz processor clock, one synchronous active-high reset
// Notes:   Field lengths are clock cycles; positive drive moves outward
package dss_pkg;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CYL_W          = 16;
    localparam int ADC_W          = 10;
    localparam int DAC_W          = 12;
    localparam int CNT_W          = 24;
    localparam int FCNT_W         = 16;
    localparam int NUM_BURSTS     = 4;
    localparam int PULSES_PER_REV = 6;

    // Servo frame field lengths
    localparam logic [FCNT_W-1:0] RECOVERY_CYC  = 16'h0028;
    localparam logic [FCNT_W-1:0] MARK_WAIT_CYC = 16'h00c8;
    localparam logic [FCNT_W-1:0] GRAY_BIT_CYC  = 16'h0008;
    localparam logic [FCNT_W-1:0] BURST_CYC     = 16'h0020;
    localparam logic [FCNT_W-1:0] PAD_CYC       = 16'h0018;

    // Spindle and head-load timing
    localparam int REF_REV_NS   = 11111000;
    localparam int REF_REV_CYC  = REF_REV_NS / CLK_PERIOD_NS;
    localparam int CHARGE_US    = 1000;
    localparam int CHARGE_CYC   = CHARGE_US * 1000 / CLK_PERIOD_NS;
    localparam int HOLD_US      = 2000;
    localparam int HOLD_CYC     = HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam int PUMP_K_SHIFT = 2;

    // Actuator drive levels and loop gains
    localparam logic signed [19:0] HOLD_DRIVE  = 20'shfffe0;
    localparam logic signed [19:0] OUT_DRIVE   = 20'sh00100;
    localparam logic signed [19:0] CREEP_DRIVE = 20'sh00040;
    localparam logic signed [19:0] CREEP_SPEED = 20'sh00002;
    localparam logic signed [19:0] DRV_MAX     = 20'sh007ff;
    localparam logic signed [19:0] DRV_MIN     = 20'shff800;
    localparam int SEEK_SHL = 2;
    localparam int KP_SHL   = 1;
    localparam int KD_SHL   = 2;

    // Spindle mode codes
    localparam logic [1:0] MODE_START  = 2'h1;
    localparam logic [1:0] MODE_ACCEL  = 2'h2;
    localparam logic [1:0] MODE_STABLE = 2'h3;

    typedef enum logic [5:0] {
        F_RECOV  = 6'h01,
        F_COARSE = 6'h02,
        F_PREAM  = 6'h04,
        F_GRAY   = 6'h08,
        F_BURST  = 6'h10,
        F_PAD    = 6'h20
    } dss_frame_t;

    typedef enum logic [4:0] {
        A_HOLD   = 5'h01,
        A_OUT    = 5'h02,
        A_CREEP  = 5'h04,
        A_FOLLOW = 5'h08,
        A_SEEK   = 5'h10
    } dss_act_t;

    typedef enum logic [3:0] {
        SP_CHARGE = 4'h1,
        SP_START  = 4'h2,
        SP_ACCEL  = 4'h4,
        SP_STABLE = 4'h8
    } dss_spin_t;
endpackage : dss_pkg

/* File: hdl/dss_gray2bin.sv */
// Purpose: Gray code to binary conversion of the cylinder field
// Assumes: Combinational, result used in the cycle the field completes
// Notes:   Cascaded exclusive-OR from the top bit downward
module dss_gray2bin #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] i_gray,
    output logic      [W-1:0] o_bin
);
    assign o_bin[W-1] = i_gray[W-1];
    for (genvar k = 0; k < W - 1; k++) begin : g_xor
        assign o_bin[k] = o_bin[k+1] ^ i_gray[k];
    end
endmodule : dss_gray2bin

/* File: hdl/dss_servo_spindle.sv */
// Purpose: Servo frame decode, actuator loops and spindle sequencing
// Assumes: Mark, gray and rotation inputs are asynchronous pins
// Notes:   ADC data and firmware controls share the processor clock
// Function
// - Frame: recovery, mark, preamble, gray, bursts, pad
// - Servo mark opens gray and burst windows
// - Preamble locks; fine mark searched after coarse
// - Gray cylinder field with index converted binary
// - On track, burst A amplitude equals B
// - Four bursts captured under the sample strobe
// - Drive current updated once per servo sample
// - Head load: hold inner, outward, creep, follow
// - Cylinder zero is the outermost circumference
// - Seek drives cylinder error until target reached
// - Otherwise track follow with compensation filtering
// - Spindle modes: start, acceleration, stable rotation
// - Charge pump first, then motor start mode
// - No rotation pulse in time resets, restarts
// - No commutation signals during acceleration mode
// - Accelerate until target speed, then stable
// - Stable: charge if slow, discharge if fast
// - Correction applied every sixth of a revolution
// - Periodic speed measurement sets motor current
// - Drive value sent to the actuator DAC
module dss_servo_spindle
    import dss_pkg::*;
#(
    parameter int HOLD_CYCLES    = HOLD_CYC,
    parameter int CHARGE_CYCLES  = CHARGE_CYC,
    parameter int REF_REV_CYCLES = REF_REV_CYC
) (
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clk_en,
    input  wire logic             i_coarse_servo_mark,
    input  wire logic             i_fine_servo_mark,
    input  wire logic             i_gray_bit,
    input  wire logic [ADC_W-1:0] i_adc_data,
    input  wire logic             i_rotation_pulse,
    input  wire logic [CNT_W-1:0] i_start_timeout,
    input  wire logic             i_timeout_clr,
    input  wire logic             i_seek_req,
    input  wire logic [CYL_W-1:0] i_seek_target,
    input  wire logic [CYL_W-1:0] i_ref_cylinder,
    output logic                  o_burst_sample_strobe,
    output logic      [1:0]       o_burst_sel,
    output logic      [CYL_W-1:0] o_cylinder,
    output logic                  o_index,
    output logic                  o_frame_done,
    output logic      [DAC_W-1:0] o_dac_value,
    output logic                  o_dac_load,
    output logic                  o_tracking,
    output logic                  o_seek_done,
    output logic      [1:0]       o_spin_mode,
    output logic                  o_motor_run,
    output logic                  o_commutate_en,
    output logic                  o_driver_reset,
    output logic                  o_pump_charge,
    output logic                  o_pump_discharge,
    output logic                  o_start_timeout
);
    function automatic logic [DAC_W-1:0] dss_sat(
        input logic signed [19:0] v
    );
        if (v > DRV_MAX) begin
            return DRV_MAX[DAC_W-1:0];
        end else if (v < DRV_MIN) begin
            return DRV_MIN[DAC_W-1:0];
        end
        return v[DAC_W-1:0];
    endfunction : dss_sat

    // Pin synchronisers
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       rot_d3_q;
    wire  [3:0] pins = {i_rotation_pulse, i_gray_bit, i_fine_servo_mark,
                        i_coarse_servo_mark};
    wire        coarse_s  = sync2_q[0];
    wire        fine_s    = sync2_q[1];
    wire        gray_s    = sync2_q[2];
    wire        rot_pulse = sync2_q[3] & ~rot_d3_q;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sync1_q  <= 4'h0;
            sync2_q  <= 4'h0;
            rot_d3_q <= 1'b0;
        end else if (i_clk_en) begin
            sync1_q  <= pins;
            sync2_q  <= sync1_q;
            rot_d3_q <= sync2_q[3];
        end
    end

    // Servo frame decoder
    dss_frame_t        fs_q;
    dss_frame_t        fs_d;
    logic [FCNT_W-1:0] fcnt_q;
    logic [4:0]        bit_q;
    logic [1:0]        bsel_q;
    logic [CYL_W:0]    gshift_q;
    logic [CYL_W-1:0]  cyl_q;
    logic [CYL_W-1:0]  cyl_bin;
    logic [ADC_W-1:0]  burst_q [NUM_BURSTS];

    wire [FCNT_W-1:0] f_lim = (fs_q == F_RECOV) ? RECOVERY_CYC :
                              (fs_q == F_PREAM) ? MARK_WAIT_CYC :
                              (fs_q == F_GRAY)  ? GRAY_BIT_CYC :
                              (fs_q == F_BURST) ? BURST_CYC : PAD_CYC;
    wire fend       = (fcnt_q == f_lim - 16'h0001);
    wire gray_take  = (fs_q == F_GRAY) & fend;
    wire gray_last  = gray_take & (bit_q == 5'(CYL_W));
    wire burst_take = (fs_q == F_BURST) & fend;
    wire burst_last = burst_take & (bsel_q == 2'h3);
    wire frame_done = (fs_q == F_PAD) & fend;
    wire mark_seen  = (fs_q == F_COARSE) & coarse_s;
    wire [CYL_W:0] gray_word = {gshift_q[CYL_W-1:0], gray_s};

    always_comb begin
        fs_d = fs_q;
        case (fs_q)
            F_RECOV:  if (fend) fs_d = F_COARSE;
            F_COARSE: if (coarse_s) fs_d = F_PREAM;
            F_PREAM: begin
                if (fine_s) fs_d = F_GRAY;
                else if (fend) fs_d = F_COARSE;
            end
            F_GRAY:   if (gray_last) fs_d = F_BURST;
            F_BURST:  if (burst_last) fs_d = F_PAD;
            F_PAD:    if (frame_done) fs_d = F_RECOV;
            default:  fs_d = F_RECOV;
        endcase
    end

    dss_gray2bin #(
        .W (CYL_W)
    ) u_gray (
        .i_gray (gray_word[CYL_W-1:0]),
        .o_bin  (cyl_bin)
    );

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            fs_q                  <= F_RECOV;
            fcnt_q                <= '0;
            bit_q                 <= '0;
            bsel_q                <= '0;
            gshift_q              <= '0;
            cyl_q                 <= '0;
            o_index               <= 1'b0;
            o_burst_sample_strobe <= 1'b0;
            o_frame_done          <= 1'b0;
        end else if (i_clk_en) begin
            fs_q   <= fs_d;
            fcnt_q <= (fend || fs_d != fs_q) ? '0 : fcnt_q + 1'b1;
            bit_q  <= (fs_q != F_GRAY) ? '0 : bit_q + {4'h0, gray_take};
            bsel_q <= (fs_q != F_BURST) ? '0 : bsel_q + {1'b0, burst_take};
            if (gray_take) begin
                gshift_q <= gray_word;
            end
            if (gray_last) begin
                cyl_q   <= cyl_bin;
                o_index <= gray_word[CYL_W];
            end
            o_burst_sample_strobe <= (fs_d == F_BURST);
            o_frame_done          <= frame_done;
        end
    end

    for (genvar b = 0; b < NUM_BURSTS; b++) begin : g_burst
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                burst_q[b] <= '0;
            end else if (i_clk_en && burst_take && bsel_q == 2'(b)) begin
                burst_q[b] <= i_adc_data;
            end
        end
    end

    assign o_cylinder  = cyl_q;
    assign o_burst_sel = bsel_q;

    // Actuator loops
    dss_act_t          act_q;
    dss_act_t          act_d;
    logic [CNT_W-1:0]  hcnt_q;
    logic [CYL_W-1:0]  target_q;
    logic [CYL_W-1:0]  cyl_prev_q;
    logic signed [19:0] pe_prev_q;
    logic [DAC_W-1:0]  dac_q;
    dss_spin_t         spin_q;
    dss_spin_t         spin_d;

    // Burst A minus burst B is the off-track error
    wire signed [19:0] pos_err = 20'($signed({1'b0, burst_q[0]}) -
                                     $signed({1'b0, burst_q[1]}));
    wire signed [19:0] cyl_err = 20'($signed({1'b0, cyl_q}) -
                                     $signed({1'b0, target_q}));
    wire signed [19:0] speed   = 20'($signed({1'b0, cyl_prev_q}) -
                                     $signed({1'b0, cyl_q}));
    wire signed [19:0] seek_drv   = cyl_err <<< SEEK_SHL;
    wire signed [19:0] creep_drv  = CREEP_DRIVE +
                                    ((CREEP_SPEED - speed) <<< KP_SHL);
    wire signed [19:0] follow_drv = (pos_err <<< KP_SHL) +
                                    ((pos_err - pe_prev_q) <<< KD_SHL);
    wire seek_ok = i_seek_req & (spin_q == SP_STABLE) &
                   (i_seek_target != cyl_q);
    wire at_ref  = (cyl_q <= i_ref_cylinder);

    always_comb begin
        act_d = act_q;
        case (act_q)
            A_HOLD:   if (hcnt_q == CNT_W'(HOLD_CYCLES - 1)) act_d = A_OUT;
            A_OUT:    if (mark_seen) act_d = A_CREEP;
            A_CREEP:  if (frame_done && at_ref) act_d = A_FOLLOW;
            A_FOLLOW: if (seek_ok) act_d = A_SEEK;
            A_SEEK:   if (frame_done && cyl_q == target_q) act_d = A_FOLLOW;
            default:  act_d = A_HOLD;
        endcase
    end

    wire hold_go = (act_q == A_HOLD) & (hcnt_q == '0);
    wire out_go  = (act_q == A_HOLD) & (act_d == A_OUT);
    wire loop_go = frame_done & ((act_q == A_CREEP) | (act_q == A_FOLLOW) |
                                 (act_q == A_SEEK));
    wire dac_upd = hold_go | out_go | loop_go;
    wire signed [19:0] drv_sel = hold_go ? HOLD_DRIVE :
                                 out_go ? OUT_DRIVE :
                                 (act_q == A_CREEP) ? creep_drv :
                                 (act_q == A_SEEK) ? seek_drv :
                                 follow_drv;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            act_q       <= A_HOLD;
            hcnt_q      <= '0;
            target_q    <= '0;
            cyl_prev_q  <= '0;
            pe_prev_q   <= '0;
            dac_q       <= '0;
            o_dac_load  <= 1'b0;
            o_tracking  <= 1'b0;
            o_seek_done <= 1'b0;
        end else if (i_clk_en) begin
            act_q <= act_d;
            if (act_q == A_HOLD) begin
                hcnt_q <= hcnt_q + 1'b1;
            end
            if (act_q == A_CREEP && act_d == A_FOLLOW) begin
                target_q <= i_ref_cylinder;
            end else if (act_q == A_FOLLOW && act_d == A_SEEK) begin
                target_q <= i_seek_target;
            end
            if (frame_done) begin
                cyl_prev_q <= cyl_q;
                pe_prev_q  <= pos_err;
            end
            if (dac_upd) begin
                dac_q <= dss_sat(drv_sel);
            end
            o_dac_load  <= dac_upd;
            o_tracking  <= (act_d == A_FOLLOW);
            o_seek_done <= (act_q == A_SEEK) & (act_d == A_FOLLOW);
        end
    end

    assign o_dac_value = dac_q;

    // Spindle sequencer
    logic [CNT_W-1:0] scnt_q;
    logic [CNT_W-1:0] pcnt_q;
    logic             dir_q;

    wire [CNT_W+2:0] rev_est  = ((CNT_W+3)'(scnt_q) + (CNT_W+3)'(1)) *
                                (CNT_W+3)'(PULSES_PER_REV);
    wire [CNT_W+2:0] rev_ref  = (CNT_W+3)'(REF_REV_CYCLES);
    wire             rev_slow = (rev_est > rev_ref);
    wire [CNT_W+2:0] rev_diff = rev_slow ? rev_est - rev_ref
                                         : rev_ref - rev_est;
    wire [CNT_W+2:0] corr_w   = rev_diff >> PUMP_K_SHIFT;
    wire [CNT_W-1:0] corr     = (|corr_w[CNT_W+2:CNT_W]) ? '1
                                : corr_w[CNT_W-1:0];
    wire tmo_set = (spin_q == SP_START) & ~rot_pulse &
                   (scnt_q >= i_start_timeout);
    wire pump_on = (spin_q == SP_STABLE) & (pcnt_q != '0);

    always_comb begin
        spin_d = spin_q;
        case (spin_q)
            SP_CHARGE: begin
                if (scnt_q == CNT_W'(CHARGE_CYCLES - 1)) spin_d = SP_START;
            end
            SP_START: begin
                if (rot_pulse) spin_d = SP_ACCEL;
                else if (tmo_set) spin_d = SP_CHARGE;
            end
            SP_ACCEL:  if (rot_pulse && !rev_slow) spin_d = SP_STABLE;
            SP_STABLE: spin_d = SP_STABLE;
            default:   spin_d = SP_CHARGE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            spin_q           <= SP_CHARGE;
            scnt_q           <= '0;
            pcnt_q           <= '0;
            dir_q            <= 1'b0;
            o_pump_charge    <= 1'b0;
            o_pump_discharge <= 1'b0;
            o_motor_run      <= 1'b0;
            o_commutate_en   <= 1'b0;
            o_driver_reset   <= 1'b0;
            o_start_timeout  <= 1'b0;
            o_spin_mode      <= MODE_START;
        end else if (i_clk_en) begin
            spin_q <= spin_d;
            scnt_q <= (spin_d != spin_q || rot_pulse) ? '0 :
                      (&scnt_q) ? scnt_q : scnt_q + 1'b1;
            if (spin_q == SP_STABLE && rot_pulse) begin
                pcnt_q <= corr;
                dir_q  <= rev_slow;
            end else if (pcnt_q != '0) begin
                pcnt_q <= pcnt_q - 1'b1;
            end
            o_pump_charge    <= (spin_q == SP_CHARGE) |
                                (spin_q == SP_ACCEL) |
                                (pump_on & dir_q);
            o_pump_discharge <= pump_on & ~dir_q;
            o_motor_run      <= (spin_q != SP_CHARGE);
            o_commutate_en   <= (spin_q == SP_START);
            o_driver_reset   <= tmo_set;
            o_start_timeout  <= tmo_set | (o_start_timeout & ~i_timeout_clr);
            o_spin_mode      <= (spin_q == SP_STABLE) ? MODE_STABLE :
                                (spin_q == SP_ACCEL) ? MODE_ACCEL :
                                MODE_START;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    AST_FIELD_ORDER: assert property (
        $rose(fs_q == F_GRAY) |-> $past(fs_q == F_PREAM))
        else $error("Gray field not entered from preamble");
    AST_FINE_AFTER_COARSE: assert property (
        $rose(fs_q == F_PREAM) |-> $past(fs_q == F_COARSE && coarse_s))
        else $error("Fine mark search began without coarse mark");
    AST_STROBE_WINDOW: assert property (
        o_burst_sample_strobe |-> fs_q == F_BURST)
        else $error("Burst strobe outside burst window");
    AST_GRAY_BIN: assert property (
        $past(gray_last && i_clk_en) |->
            (o_cylinder ^ (o_cylinder >> 1)) == $past(gray_word[CYL_W-1:0]))
        else $error("Cylinder is not the binary of the gray field");
    AST_SEEK_LOAD: assert property (
        $past(i_clk_en && frame_done && act_q == A_SEEK) |-> o_dac_load)
        else $error("Seek sample did not load the DAC");
    AST_CREEP_TO_FOLLOW: assert property (
        i_clk_en && act_q == A_CREEP && frame_done && at_ref
            |=> act_q == A_FOLLOW)
        else $error("Head load did not hand over at reference");
    AST_SEEK_STEADY: assert property (
        $rose(act_q == A_SEEK) |-> $past(spin_q == SP_STABLE))
        else $error("Seek started without steady spindle");
    AST_START_AFTER_CHARGE: assert property (
        $rose(o_motor_run) |-> $past(o_pump_charge))
        else $error("Motor start without prior pump charge");
    AST_TIMEOUT_RESET: assert property (
        $rose(o_start_timeout) |-> o_driver_reset ##1 !o_motor_run)
        else $error("Start timeout without driver reset");
    AST_NO_COMMUTATE_ACCEL: assert property (
        spin_q == SP_ACCEL && $past(spin_q == SP_ACCEL) |-> !o_commutate_en)
        else $error("Commutation issued in acceleration");
    AST_PUMP_EXCL: assert property (
        o_pump_discharge |-> !o_pump_charge && o_spin_mode == MODE_STABLE)
        else $error("Pump discharge outside stable mode");
endmodule : dss_servo_spindle

/* File: verif/dss_spindle_model.sv */
// Purpose: Spindle driver stand-in giving rotation pulses and phases
// Assumes: Pulse spacing in clock cycles is set by the bench
// Notes:   Back-EMF commutation is a free-running phase counter
module dss_spindle_model (
    input  wire logic        i_clock,
    input  wire logic        i_motor_run,
    input  wire logic        i_commutate_en,
    input  wire logic        i_driver_reset,
    input  wire logic [15:0] i_period,
    output logic             o_rotation_pulse,
    output logic [2:0]       o_phase
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q = 16'h0000;
    logic [2:0]  step_q = 3'h0;

    // Driver reset or motor off stops rotation and phase stepping
    always @(posedge i_clock) begin
        if (i_driver_reset || !i_motor_run) begin
            cnt_q <= 16'h0000;
            step_q <= 3'h0;
        end else begin
            cnt_q <= (cnt_q >= i_period - 16'h0001) ? 16'h0000
                                                    : cnt_q + 16'h0001;
            if (cnt_q[2:0] == 3'h7) begin
                // Steps 0..4: V-U, W-U, W-V, U-V, V-W, then repeat
                step_q <= (step_q == 3'h4) ? 3'h0 : step_q + 3'h1;
            end
        end
    end

    // Same order whether commanded or self-commutated from back-EMF
    assign o_phase = step_q;
    assign o_rotation_pulse = cnt_q >= i_period - 16'h0004;
endmodule : dss_spindle_model

/* File: verif/dss_servo_spindle_bench.sv */
// Purpose: Self-checking bench for the servo and spindle sequencer
// Assumes: Driver model on the far side, short count parameters
// Notes:   Inputs change at the falling clock edge
module dss_servo_spindle_bench
    import dss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             i_clock = 1'b0;
    logic             i_sys_rst = 1'b1;
    logic             i_clk_en = 1'b1;
    logic             i_coarse_servo_mark = 1'b0;
    logic             i_fine_servo_mark = 1'b0;
    logic             i_gray_bit = 1'b0;
    logic [ADC_W-1:0] i_adc_data = '0;
    logic             i_rotation_pulse;
    logic [CNT_W-1:0] i_start_timeout = 24'h000040;
    logic             i_timeout_clr = 1'b0;
    logic             i_seek_req = 1'b0;
    logic [CYL_W-1:0] i_seek_target = 16'h0010;
    logic [CYL_W-1:0] i_ref_cylinder = 16'h0010;
    logic             o_burst_sample_strobe, o_index, o_frame_done;
    logic             o_dac_load, o_tracking, o_seek_done, o_motor_run;
    logic             o_commutate_en, o_driver_reset, o_pump_charge;
    logic             o_pump_discharge, o_start_timeout;
    logic [1:0]       o_burst_sel, o_spin_mode;
    logic [CYL_W-1:0] o_cylinder;
    logic [DAC_W-1:0] o_dac_value;
    logic [15:0]      period = 16'h03e8;
    logic [ADC_W-1:0] adc [4] = '{default: '0};
    logic             seen_done = 1'b0;
    int               n_fail = 0;
    int               n_compared = 0;
    int               nl;
    logic [2:0]       phase;

    dss_servo_spindle #(
        .HOLD_CYCLES   (20),
        .CHARGE_CYCLES (20),
        .REF_REV_CYCLES(600)
    ) uut (
        .i_clock, .i_sys_rst, .i_clk_en, .i_coarse_servo_mark,
        .i_fine_servo_mark, .i_gray_bit, .i_adc_data, .i_rotation_pulse,
        .i_start_timeout, .i_timeout_clr, .i_seek_req, .i_seek_target,
        .i_ref_cylinder, .o_burst_sample_strobe, .o_burst_sel, .o_cylinder,
        .o_index, .o_frame_done, .o_dac_value, .o_dac_load, .o_tracking,
        .o_seek_done, .o_spin_mode, .o_motor_run, .o_commutate_en,
        .o_driver_reset, .o_pump_charge, .o_pump_discharge, .o_start_timeout
    );

    dss_spindle_model model (
        .i_clock, .i_motor_run(o_motor_run), .i_commutate_en(o_commutate_en),
        .i_driver_reset(o_driver_reset), .i_period(period),
        .o_rotation_pulse(i_rotation_pulse), .o_phase(phase)
    );

    always #5 i_clock = ~i_clock;
    always @(negedge i_clock) i_adc_data <= adc[o_burst_sel];
    always @(posedge i_clock) if (o_seek_done === 1'b1) seen_done <= 1'b1;

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask : cyc

    task automatic wait_hi(ref logic s, input int lim);
        repeat (lim) begin
            if (s === 1'b1) break;
            cyc(1);
        end
        check(24'(s), 24'h000001);
    endtask : wait_hi

    task automatic wait_mode(input logic [1:0] m, input int lim);
        repeat (lim) begin
            if (o_spin_mode === m) break;
            cyc(1);
        end
        check(24'(o_spin_mode), 24'(m));
    endtask : wait_mode

    // One servo frame: marks, index plus gray cylinder, four bursts
    task automatic frame(input logic [15:0] cyl, input logic [9:0] a, b,
                         output int n_load);
        logic [16:0] g;
        int ns;
        g = {cyl[4], cyl ^ (cyl >> 1)};
        adc = '{a, b, 10'h055, 10'h0aa};
        ns = 0;
        n_load = 0;
        i_coarse_servo_mark = 1'b1;
        cyc(60);
        i_fine_servo_mark = 1'b1;
        cyc(3);
        i_coarse_servo_mark = 1'b0;
        i_fine_servo_mark = 1'b0;
        for (int k = 16; k >= 0; k--) begin
            i_gray_bit = g[k];
            cyc(8);
        end
        repeat (400) begin
            if (o_frame_done === 1'b1) break;
            ns += o_burst_sample_strobe;
            n_load += o_dac_load;
            cyc(1);
        end
        repeat (3) begin
            n_load += o_dac_load;
            cyc(1);
        end
        check(24'(o_cylinder), 24'(cyl));
        check(24'(o_index), 24'(cyl[4]));
        check(24'(ns), 24'(4 * BURST_CYC));
    endtask : frame

    task automatic count_pump(input int n, input int ec, input int ed);
        int c;
        int d;
        c = 0;
        d = 0;
        repeat (n) begin
            c += o_pump_charge;
            d += o_pump_discharge;
            cyc(1);
        end
        check(24'(c), 24'(ec));
        check(24'(d), 24'(ed));
    endtask : count_pump

    initial begin
        cyc(10);
        check(24'(o_spin_mode), 24'(MODE_START));
        i_sys_rst = 1'b0;
        wait_hi(o_dac_load, 5);
        check(24'(o_dac_value), 24'h000fe0);
        check(24'(o_pump_charge), 24'h000001);
        check(24'(o_motor_run), 24'h000000);
        cyc(1);
        wait_hi(o_dac_load, 40);
        check(24'(o_dac_value), 24'h000100);
        $display("test reset done");
        wait_hi(o_driver_reset, 300);
        cyc(2);
        check(24'(o_start_timeout), 24'h000001);
        check(24'(o_motor_run), 24'h000000);
        i_start_timeout = 24'hffffff;
        i_timeout_clr = 1'b1;
        cyc(1);
        i_timeout_clr = 1'b0;
        cyc(2);
        check(24'(o_start_timeout), 24'h000000);
        wait_hi(o_commutate_en, 100);
        cyc(20);
        check(24'(phase), 24'h000002);
        $display("test timeout done");
        frame(16'h0030, 10'h100, 10'h100, nl);
        check(24'(o_tracking), 24'h000000);
        frame(16'h0008, 10'h100, 10'h100, nl);
        check(24'(o_tracking), 24'h000001);
        i_seek_req = 1'b1;
        cyc(10);
        check(24'(o_tracking), 24'h000001);
        i_seek_req = 1'b0;
        frame(16'h0008, 10'h100, 10'h100, nl);
        check(24'(nl), 24'h000001);
        check(24'(o_dac_value), 24'h000000);
        frame(16'h0008, 10'h110, 10'h100, nl);
        check(24'(o_dac_value), 24'h000060);
        frame(16'h0008, 10'h110, 10'h100, nl);
        check(24'(o_dac_value), 24'h000020);
        $display("test actuator done");
        period = 16'h0064;
        wait_mode(MODE_ACCEL, 1200);
        check(24'(o_commutate_en), 24'h000000);
        wait_mode(MODE_STABLE, 400);
        period = 16'h0078;
        cyc(400);
        count_pump(120, 30, 0);
        period = 16'h0050;
        cyc(400);
        count_pump(80, 0, 30);
        period = 16'h0064;
        cyc(300);
        $display("test spindle done");
        i_seek_req = 1'b1;
        cyc(4);
        check(24'(o_tracking), 24'h000000);
        i_seek_req = 1'b0;
        frame(16'h0400, 10'h100, 10'h100, nl);
        check(24'(o_dac_value), 24'h0007ff);
        frame(16'h0008, 10'h100, 10'h100, nl);
        check(24'(o_dac_value), 24'h000fe0);
        seen_done = 1'b0;
        frame(16'h0010, 10'h100, 10'h100, nl);
        check(24'(seen_done), 24'h000001);
        check(24'(o_tracking), 24'h000001);
        $display("test seek done");
        stop_test();
    end

    initial begin
        #500000;
        n_fail++;
        stop_test();
    end
endmodule : dss_servo_spindle_bench
